// *** hdl/mbc_buf.sv ***
// two-entry buffer for read bytes, head entry always in slot 0
// assumes the writer only pushes while in_ready_o is high
`timescale 1ns/1ps
module mbc_buf (
  // clock and reset
  input  wire logic                CLK_SYS_I,
  input  wire logic                RST_I,
  // fill side
  input  wire logic                in_valid_i,
  input  wire mbc_pkg::mbc_rd_type in_data_i,
  output logic                     in_ready_o,
  // drain side
  output logic                     out_valid_o,
  output mbc_pkg::mbc_rd_type      out_data_o,
  input  wire logic                out_ready_i
);

  logic                vld0_ff;
  logic                vld1_ff;
  mbc_pkg::mbc_rd_type ent0_ff;
  mbc_pkg::mbc_rd_type ent1_ff;
  logic                pop;

  assign pop         = vld0_ff && out_ready_i;
  assign in_ready_o  = !vld1_ff;
  assign out_valid_o = vld0_ff;
  assign out_data_o  = ent0_ff;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      vld0_ff <= 1'b0;
      vld1_ff <= 1'b0;
      ent0_ff <= '0;
      ent1_ff <= '0;
    end else if (in_valid_i && !pop) begin
      if (!vld0_ff) begin
        ent0_ff <= in_data_i;
        vld0_ff <= 1'b1;
      end else begin
        ent1_ff <= in_data_i;
        vld1_ff <= 1'b1;
      end
    end else if (pop && !in_valid_i) begin
      ent0_ff <= ent1_ff;
      vld0_ff <= vld1_ff;
      vld1_ff <= 1'b0;
    end else if (pop && in_valid_i) begin
      if (vld1_ff) begin
        ent0_ff <= ent1_ff;
        ent1_ff <= in_data_i;
      end else begin
        ent0_ff <= in_data_i;
      end
    end
  end

endmodule

// *** hdl/mbc_master.sv ***
// two-wire bus master issuing broadcast write and broadcast read transactions
// assumes open-drain bus wires resolved outside; pins are asynchronous to the clock
`timescale 1ns/1ps

module mbc_master (
  // clock and reset
  input  wire logic                CLK_SYS_I,
  input  wire logic                RST_I,
  // command
  input  wire logic                CMD_VALID_I,
  input  wire mbc_pkg::mbc_cmd_type CMD_I,
  output logic                     CMD_READY_O,
  // read bytes
  output logic                     RD_VALID_O,
  output mbc_pkg::mbc_rd_type      RD_O,
  input  wire logic                RD_READY_I,
  // status
  output logic                     DONE_O,
  output logic                     NACK_O,
  // bus pins
  input  wire logic                SCL_I,
  output logic                     SCL_O,
  output logic                     SCL_OE_N_O,
  input  wire logic                SDA_I,
  output logic                     SDA_O,
  output logic                     SDA_OE_N_O
);

  // ***************************************************************
  // pin synchronisers and quarter-bit divider
  // ***************************************************************
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic       scl_s;
  logic       sda_s;
  logic [7:0] qcnt_ff;
  logic       tick;

  mbc_pkg::mbc_state_type state_ff;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], SCL_I};
      sda_sync_ff <= {sda_sync_ff[0], SDA_I};
    end
  end

  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];
  assign tick  = (qcnt_ff == 8'h00);

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      qcnt_ff <= mbc_pkg::QTR_LOAD;
    end else if (state_ff == mbc_pkg::ST_IDLE || tick) begin
      qcnt_ff <= mbc_pkg::QTR_LOAD;
    end else begin
      qcnt_ff <= qcnt_ff - 8'h01;
    end
  end

  // ***************************************************************
  // transaction sequencer
  // ***************************************************************
  logic [1:0]           q_ff;
  logic [3:0]           bit_ff;
  logic [1:0]           stage_ff;
  logic [2:0]           slot_ff;
  logic [7:0]           sh_ff;
  logic                 rx_ff;
  logic                 ackbad_ff;
  logic                 free_ff;
  logic                 scl_oe_n_ff;
  logic                 sda_oe_n_ff;
  logic                 ready_ff;
  logic                 done_ff;
  logic                 nack_ff;
  logic                 push_ff;
  mbc_pkg::mbc_rd_type  push_data_ff;
  mbc_pkg::mbc_cmd_type cmd_ff;
  logic                 buf_ready;
  logic                 last_slot;
  logic                 stall;

  assign last_slot = (slot_ff == cmd_ff.last_slot);
  // clock stretching: the high phase only counts once the wire is really high
  assign stall = (q_ff == 2'h2 && !scl_s) ||
                 (state_ff == mbc_pkg::ST_BIT && q_ff == 2'h0 && rx_ff &&
                  bit_ff == 4'h0 && !buf_ready);

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff     <= mbc_pkg::ST_IDLE;
      q_ff         <= 2'h0;
      bit_ff       <= 4'h0;
      stage_ff     <= mbc_pkg::STG_ADDR;
      slot_ff      <= 3'h0;
      sh_ff        <= 8'h00;
      rx_ff        <= 1'b0;
      ackbad_ff    <= 1'b0;
      free_ff      <= 1'b0;
      scl_oe_n_ff  <= 1'b1;
      sda_oe_n_ff  <= 1'b1;
      ready_ff     <= 1'b0;
      done_ff      <= 1'b0;
      nack_ff      <= 1'b0;
      push_ff      <= 1'b0;
      push_data_ff <= '0;
      cmd_ff       <= '0;
    end else begin
      done_ff <= 1'b0;
      push_ff <= 1'b0;
      case (state_ff)
        mbc_pkg::ST_IDLE: begin
          ready_ff <= 1'b1;
          free_ff  <= 1'b0;
          if (CMD_VALID_I && ready_ff) begin
            cmd_ff   <= CMD_I;
            ready_ff <= 1'b0;
            nack_ff  <= 1'b0;
            stage_ff <= mbc_pkg::STG_ADDR;
            q_ff     <= 2'h0;
            state_ff <= mbc_pkg::ST_FREE;
          end
        end
        mbc_pkg::ST_FREE: begin
          // both lines high over a full quarter also gives the bus free time
          if (tick) begin
            free_ff <= scl_s && sda_s;
            if (free_ff && scl_s && sda_s) begin
              state_ff <= mbc_pkg::ST_START;
            end
          end
        end
        mbc_pkg::ST_START: begin
          // also serves as repeated start between pointer write and read
          if (tick && !stall) begin
            q_ff <= q_ff + 2'h1;
            case (q_ff)
              2'h0: sda_oe_n_ff <= 1'b1;
              2'h1: scl_oe_n_ff <= 1'b1;
              2'h2: sda_oe_n_ff <= 1'b0;
              default: begin
                scl_oe_n_ff <= 1'b0;
                bit_ff      <= 4'h0;
                rx_ff       <= 1'b0;
                state_ff    <= mbc_pkg::ST_BIT;
                sh_ff       <= (stage_ff == mbc_pkg::STG_ADDR) ? mbc_pkg::ADDR_BCAST_WR
                                                               : mbc_pkg::ADDR_BCAST_RD;
              end
            endcase
          end
        end
        mbc_pkg::ST_BIT: begin
          if (tick && !stall) begin
            q_ff <= q_ff + 2'h1;
            case (q_ff)
              2'h0: begin
                if (bit_ff != mbc_pkg::ACK_BIT) begin
                  sda_oe_n_ff <= rx_ff | sh_ff[7];
                end else begin
                  sda_oe_n_ff <= !rx_ff | last_slot;
                end
              end
              2'h1: scl_oe_n_ff <= 1'b1;
              2'h2: begin
                if (bit_ff != mbc_pkg::ACK_BIT) begin
                  sh_ff <= {sh_ff[6:0], sda_s};
                end else begin
                  ackbad_ff <= sda_s;
                end
              end
              default: begin
                scl_oe_n_ff <= 1'b0;
                if (bit_ff != mbc_pkg::ACK_BIT) begin
                  bit_ff <= bit_ff + 4'h1;
                  if (rx_ff && bit_ff == mbc_pkg::LAST_DATA_BIT) begin
                    push_ff      <= 1'b1;
                    push_data_ff <= '{slot: slot_ff, data: sh_ff};
                  end
                end else begin
                  bit_ff <= 4'h0;
                  if (!rx_ff && ackbad_ff) begin
                    nack_ff  <= 1'b1;
                    state_ff <= mbc_pkg::ST_STOP;
                  end else begin
                    case (stage_ff)
                      mbc_pkg::STG_ADDR: begin
                        stage_ff <= mbc_pkg::STG_PTR;
                        sh_ff    <= cmd_ff.ptr;
                      end
                      mbc_pkg::STG_PTR: begin
                        stage_ff <= mbc_pkg::STG_THIRD;
                        sh_ff    <= cmd_ff.data;
                        if (cmd_ff.is_read) begin
                          state_ff <= mbc_pkg::ST_START;
                        end
                      end
                      mbc_pkg::STG_THIRD: begin
                        if (cmd_ff.is_read) begin
                          stage_ff <= mbc_pkg::STG_SLOTS;
                          rx_ff    <= 1'b1;
                          slot_ff  <= 3'h0;
                        end else begin
                          state_ff <= mbc_pkg::ST_STOP;
                        end
                      end
                      default: begin
                        // the master alone chooses how many slots to clock
                        if (last_slot) begin
                          state_ff <= mbc_pkg::ST_STOP;
                        end else begin
                          slot_ff <= slot_ff + 3'h1;
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        mbc_pkg::ST_STOP: begin
          if (tick && !stall) begin
            q_ff <= q_ff + 2'h1;
            case (q_ff)
              2'h0: sda_oe_n_ff <= 1'b0;
              2'h1: scl_oe_n_ff <= 1'b1;
              2'h2: sda_oe_n_ff <= 1'b0;
              default: begin
                sda_oe_n_ff <= 1'b1;
                rx_ff       <= 1'b0;
                done_ff     <= 1'b1;
                state_ff    <= mbc_pkg::ST_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_ff    <= mbc_pkg::ST_IDLE;
          scl_oe_n_ff <= 1'b1;
          sda_oe_n_ff <= 1'b1;
        end
      endcase
    end
  end

  // ***************************************************************
  // read byte buffer and outputs
  // ***************************************************************
  mbc_buf u_buf (
    .CLK_SYS_I   (CLK_SYS_I),
    .RST_I       (RST_I),
    .in_valid_i  (push_ff),
    .in_data_i   (push_data_ff),
    .in_ready_o  (buf_ready),
    .out_valid_o (RD_VALID_O),
    .out_data_o  (RD_O),
    .out_ready_i (RD_READY_I)
  );

  assign CMD_READY_O = ready_ff;
  assign DONE_O      = done_ff;
  assign NACK_O      = nack_ff;
  // open drain: only ever pull low, release by lifting the enable
  assign SCL_O       = 1'b0;
  assign SDA_O       = 1'b0;
  assign SCL_OE_N_O  = scl_oe_n_ff;
  assign SDA_OE_N_O  = sda_oe_n_ff;

endmodule

// *** hdl/mbc_pkg.sv ***
// constants, timing counts and carrier types of the broadcast master
// assumes a 250 MHz system clock and a fast-mode two-wire bus
package mbc_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_NS    = 4;
  localparam int T_LOW_NS  = 1300;
  localparam int T_HIGH_NS = 600;
  localparam int T_BUF_NS  = 600;
  // one bit is four quarters: two low, two high; a quarter also covers bus free and setup/hold
  localparam int QTR_CYC   = (T_LOW_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] QTR_LOAD = 8'(QTR_CYC - 1);

  // ***************************************************************
  // bus codes
  // ***************************************************************
  localparam logic [7:0] ADDR_BCAST_WR = 8'h00;
  localparam logic [7:0] ADDR_BCAST_RD = 8'h01;
  localparam logic [3:0] ACK_BIT       = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // byte position inside a transaction
  localparam logic [1:0] STG_ADDR   = 2'h0;
  localparam logic [1:0] STG_PTR    = 2'h1;
  localparam logic [1:0] STG_THIRD  = 2'h2;
  localparam logic [1:0] STG_SLOTS  = 2'h3;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef struct packed {
    logic       is_read;
    logic [2:0] last_slot;
    logic [7:0] ptr;
    logic [7:0] data;
  } mbc_cmd_type;

  typedef struct packed {
    logic [2:0] slot;
    logic [7:0] data;
  } mbc_rd_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FREE  = 3'h1,
    ST_START = 3'h3,
    ST_BIT   = 3'h2,
    ST_STOP  = 3'h6
  } mbc_state_type;

endpackage

// *** testbench/mbc_master_asserts.sv ***
// concurrent checks on the ports of the broadcast master
// assumes the bind below; counts are literals in the properties, no parameters
`timescale 1ns/1ps
module mbc_master_asserts (
  // clock and reset
  input  wire logic                CLK_SYS_I,
  input  wire logic                RST_I,
  // command and status
  input  wire logic                CMD_VALID_I,
  input  wire logic                CMD_READY_O,
  input  wire logic                DONE_O,
  input  wire logic                NACK_O,
  // read bytes
  input  wire logic                RD_VALID_O,
  input  wire mbc_pkg::mbc_rd_type RD_O,
  input  wire logic                RD_READY_I,
  // bus pins
  input  wire logic                SCL_OE_N_O,
  input  wire logic                SDA_OE_N_O
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  logic [2:0] exp_slot_ff;
  logic       take;
  assign take = CMD_VALID_I && CMD_READY_O;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      exp_slot_ff <= 3'h0;
    end else if (take) begin
      exp_slot_ff <= 3'h0;
    end else if (RD_VALID_O && RD_READY_I) begin
      exp_slot_ff <= exp_slot_ff + 3'h1;
    end
  end
  // start: data pulled while the clock wire is still released
  sequence s_start;
    ##[1:1000] !SDA_OE_N_O;
  endsequence
  sequence s_stop;
    $rose(SDA_OE_N_O) && SCL_OE_N_O;
  endsequence
  a_start_first: assert property ($fell(CMD_READY_O) |-> SCL_OE_N_O throughout s_start)
    else $error("transfer did not open with a start");
  a_stop_done: assert property (s_stop |-> DONE_O)
    else $error("stop not followed by done");
  a_done_pulse: assert property (DONE_O |=> !DONE_O && CMD_READY_O)
    else $error("done not a single pulse before ready");
  a_accept_busy: assert property (take |=> !CMD_READY_O [*8])
    else $error("ready stayed high after accept");
  a_nack_clear: assert property (take |=> !NACK_O)
    else $error("nack not cleared on accept");
  a_nack_hold: assert property (NACK_O && !take |=> NACK_O)
    else $error("nack dropped early");
  a_rd_hold: assert property (RD_VALID_O && !RD_READY_I |=> RD_VALID_O && $stable(RD_O))
    else $error("read byte changed before taken");
  a_slot_order: assert property (RD_VALID_O && RD_READY_I |-> RD_O.slot == exp_slot_ff)
    else $error("read slot out of order");
  c_read_pop: cover property (RD_VALID_O && RD_READY_I && RD_O.slot == 3'h3);
endmodule

bind mbc_master mbc_master_asserts chk_u (
  .CLK_SYS_I  (CLK_SYS_I),
  .RST_I      (RST_I),
  .CMD_VALID_I(CMD_VALID_I),
  .CMD_READY_O(CMD_READY_O),
  .DONE_O     (DONE_O),
  .NACK_O     (NACK_O),
  .RD_VALID_O (RD_VALID_O),
  .RD_O       (RD_O),
  .RD_READY_I (RD_READY_I),
  .SCL_OE_N_O (SCL_OE_N_O),
  .SDA_OE_N_O (SDA_OE_N_O)
);

// *** testbench/mbc_master_bench.sv ***
// self-checking bench: broadcast write, refused write, stalled read with a missing slot
// assumes the sensor model on an open-drain bus with pull-ups on both wires
`timescale 1ns/1ps
module mbc_master_bench;
  // ****************************************************************
  // harness
  // ****************************************************************
  localparam logic [7:0] SENSORS = 8'h8B;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 cmd_valid = 1'b0;
  logic                 rd_ready = 1'b1;
  logic                 mute = 1'b0;
  mbc_pkg::mbc_cmd_type cmd = '0;
  mbc_pkg::mbc_rd_type  rd;
  mbc_pkg::mbc_rd_type  got [$];
  logic                 cmd_ready, rd_valid, done, nack, scl_o, sda_o;
  logic                 scl_oe_n, sda_oe_n, sens_oe_n;
  wire                  scl = scl_oe_n;
  wire                  sda = sda_oe_n & sens_oe_n;
  int                   fails = 0;
  int                   comparisons = 0;
  always #2 clk = ~clk;
  mbc_master dut_u (.CLK_SYS_I(clk), .RST_I(rst), .CMD_VALID_I(cmd_valid), .CMD_I(cmd),
    .CMD_READY_O(cmd_ready), .RD_VALID_O(rd_valid), .RD_O(rd), .RD_READY_I(rd_ready),
    .DONE_O(done), .NACK_O(nack), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE_N_O(scl_oe_n),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n));
  mbc_sensor_model #(.PRESENT(SENSORS)) sens_u (.scl_i(scl), .sda_i(sda),
    .sda_oe_n_o(sens_oe_n), .mute_i(mute));
  always @(posedge clk) if (rd_valid === 1'b1 && rd_ready === 1'b1) got.push_back(rd);
  task automatic check(string what, logic [10:0] exp, logic [10:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run_cmd(logic r, logic [2:0] last, logic [7:0] p, logic [7:0] d);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd       <= {r, last, p, d};
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    for (n = 0; n < 70000 && done !== 1'b1; n++) @(negedge clk);
    check("done in time", 11'h001, 11'(n < 70000));
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_refused;
    mute <= 1'b1;
    run_cmd(1'b0, 3'h0, 8'h01, 8'h5A);
    check("nack flag", 11'h001, 11'(nack));
    mute <= 1'b0;
  endtask
  task automatic t_write;
    got.delete();
    run_cmd(1'b0, 3'h0, 8'h01, 8'hA5);
    check("nack flag", 11'h000, 11'(nack));
    check("no read bytes", 11'h000, 11'(got.size()));
  endtask
  // consumer stalls long enough to fill the buffer and hold the bus clock
  task automatic t_read_gap;
    got.delete();
    @(posedge clk);
    rd_ready <= 1'b0;
    fork
      begin
        repeat (40000) @(posedge clk);
        rd_ready <= 1'b1;
      end
      run_cmd(1'b1, 3'h3, 8'h00, 8'h00);
    join
    repeat (6) @(posedge clk);
    check("nack flag", 11'h000, 11'(nack));
    check("byte count", 11'h004, 11'(got.size()));
    for (int i = 0; i < 4; i++) begin
      check("read byte", {3'(i), SENSORS[i] ? 8'h10 + 8'(i) : 8'hFF}, got[i]);
    end
  endtask
  task automatic print_verdict;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #380000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    check("released data", 11'h001, 11'(sda_oe_n));
    check("ready in reset", 11'h000, 11'(cmd_ready));
    check("pin drive level", 11'h000, 11'({scl_o, sda_o}));
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_refused();
    t_write();
    t_read_gap();
    print_verdict();
  end
endmodule

// *** testbench/mbc_sensor_model.sv ***
// behavioural group of broadcast sensors sharing one bus, one per set bit of present
// assumes wire levels resolved by the bench with a pull-up; drives data open drain only
`timescale 1ns/1ps
module mbc_sensor_model #(
  parameter logic [7:0] PRESENT = 8'h8B
) (
  // bus wires
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_oe_n_o,
  // fault control: no sensor answers at all
  input  wire logic mute_i
);
  // ****************************************************************
  // slot logic
  // ****************************************************************
  logic       act = 1'b0;
  logic       rd  = 1'b0;
  logic [7:0] sh  = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic [7:0] mem [8][4];
  int         bitn  = 0;
  int         byten = 0;
  initial begin
    sda_oe_n_o = 1'b1;
    for (int s = 0; s < 8; s++) begin
      for (int r = 0; r < 4; r++) begin
        mem[s][r] = (r == 0) ? 8'h10 + 8'(s) : 8'h00;
      end
    end
  end
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    act   = 1'b1;
    rd    = 1'b0;
    // the clock fall that ends the start is not a bit; it brings the count to zero
    bitn  = -1;
    byten = 0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) act = 1'b0;
  always @(posedge scl_i) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda_i};
    else if (rd && byten > 0 && sda_i) act = 1'b0;
  end
  // pointer and data are shared by every present sensor, as the broadcast intends
  always @(negedge scl_i) begin
    sda_oe_n_o = 1'b1;
    if (act) begin
      if (bitn == 8) begin
        bitn  = 0;
        byten = byten + 1;
      end else begin
        bitn = bitn + 1;
        if (bitn == 8 && !(rd && byten > 0)) begin
          if (byten == 0) rd = sh[0];
          if (byten == 1) ptr = sh;
          for (int s = 0; s < 8; s++) if (byten == 2 && PRESENT[s]) mem[s][ptr[1:0]] = sh;
          sda_oe_n_o = mute_i || (byten == 0 && sh[7:1] != 7'h00);
          if (byten == 0 && sh[7:1] != 7'h00) act = 1'b0;
        end
      end
      if (rd && byten > 0 && byten <= 8 && bitn < 8 && PRESENT[byten - 1]) begin
        sda_oe_n_o = mem[byten - 1][ptr[1:0]][7 - bitn];
      end
    end
  end
endmodule
